// ===== tbcc_checker.sv
// Purpose: decodes transmit command words, strips alignment padding, checks lengths
// Assumes: host dwords arrive as valid/ready stream; mac side always accepts
// Notes: data start offset is not handled; byte counts are in whole bytes
`timescale 1ns/1ps
`default_nettype none
// Function
// - command A bit 13 starts a packet
// - command A bit 12 ends a packet
// - drop trailing alignment padding dwords
// - buffer size excludes padding and offset
// - summed buffer sizes must equal packet length
// - copy tag B[31:16] into status
// - B bit 13 suppresses fcs
// - B bit 12 suppresses short frame padding
// - padding disabled still forces fcs
// - length mismatch raises transmit error
// - A[25:24] selects end alignment
// - differing command B raises transmit error
// - A bit 31 gives buffer done flag
module tbcc_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [31:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [31:0] out_data,
  output logic out_valid,
  output logic out_last,
  output tbcc_pkg::tbcc_pkt_t pkt_info,
  output logic pkt_valid,
  output logic buffer_done_flag,
  output logic transmit_error_flag,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  typedef struct packed {
    tbcc_pkg::tbcc_state_t state;
    logic [31:0] cmd_a;
    logic [31:0] cmd_b;
    logic have_b;
    logic in_pkt;
    logic [10:0] sum;
    logic [10:0] bytes_left;
    logic [3:0] pad_left;
    logic [31:0] out_data;
    logic out_valid;
    logic out_last;
    tbcc_pkg::tbcc_pkt_t pkt_info;
    logic pkt_valid;
    logic done;
    logic err;
    logic done_sticky;
    logic enable;
    logic [31:0] rdata;
    logic ack;
    // command b differed inside the packet; reported at buffer end
    logic b_diff;
    // registered copies so every port comes straight from a flop
    logic rdy;
    logic wreq;
  } tbcc_regs_t;

  // a mismatching command b is held until the buffer closes, so every
  // error and done pulse shows up the cycle after the one turn where input is stalled

  tbcc_regs_t cur_ff;
  tbcc_regs_t nxt_cur;

  // words to strip past the last data dword, per alignment code
  function automatic logic [3:0] pad_words(input logic [1:0] al, input logic [10:0] n);
    logic [3:0] used;
    logic [3:0] total;
    used = 4'h0;
    total = 4'h1;
    case (al)
      tbcc_pkg::ALIGN_16: total = 4'h4;
      tbcc_pkg::ALIGN_32: total = 4'h8;
      default: total = 4'h1;
    endcase
    // dwords used modulo the alignment block
    used = 4'(((n + 11'h3) >> 2) & 11'(total - 4'h1));
    if (used == 4'h0)
      pad_words = 4'h0;
    else
      pad_words = total - used;
  endfunction : pad_words

  always_comb begin
    logic acc;
    logic [10:0] new_sum;
    logic last_word;
    nxt_cur = cur_ff;
    acc = 1'b0;
    new_sum = cur_ff.sum;
    last_word = 1'b0;
    nxt_cur.out_valid = 1'b0;
    nxt_cur.out_last = 1'b0;
    nxt_cur.pkt_valid = 1'b0;
    nxt_cur.done = 1'b0;
    nxt_cur.err = 1'b0;
    nxt_cur.ack = 1'b0;
    acc = in_valid && cur_ff.enable;
    case (cur_ff.state)
      tbcc_pkg::tbcc_st_cmd_a: begin
        if (acc) begin
          nxt_cur.cmd_a = in_data;
          nxt_cur.state = tbcc_pkg::tbcc_st_cmd_b;
        end
      end
      tbcc_pkg::tbcc_st_cmd_b: begin
        if (acc) begin
          nxt_cur.cmd_b = in_data;
          nxt_cur.bytes_left = cur_ff.cmd_a[tbcc_pkg::LEN_HI:0];
          nxt_cur.pad_left = pad_words(cur_ff.cmd_a[tbcc_pkg::A_ALIGN_HI:tbcc_pkg::A_ALIGN_LO],
                                       cur_ff.cmd_a[tbcc_pkg::LEN_HI:0]);
          if (cur_ff.cmd_a[tbcc_pkg::A_FIRST_BIT]) begin
            new_sum = 11'h0;
            nxt_cur.in_pkt = 1'b1;
            nxt_cur.b_diff = 1'b0;
          end else if (cur_ff.have_b && in_data != cur_ff.cmd_b) begin
            nxt_cur.b_diff = 1'b1;
          end

          nxt_cur.have_b = 1'b1;
          nxt_cur.sum = new_sum + cur_ff.cmd_a[tbcc_pkg::LEN_HI:0];
          if (cur_ff.cmd_a[tbcc_pkg::LEN_HI:0] != 11'h0)
            nxt_cur.state = tbcc_pkg::tbcc_st_data;
          else
            nxt_cur.state = tbcc_pkg::tbcc_st_pad;
        end
      end
      tbcc_pkg::tbcc_st_data: begin
        if (acc) begin
          last_word = cur_ff.bytes_left <= 11'h4;
          nxt_cur.out_data = in_data;
          nxt_cur.out_valid = 1'b1;
          nxt_cur.out_last = last_word && cur_ff.cmd_a[tbcc_pkg::A_LAST_BIT];
          nxt_cur.bytes_left = last_word ? 11'h0 : cur_ff.bytes_left - 11'h4;
          if (last_word)
            nxt_cur.state = tbcc_pkg::tbcc_st_pad;
        end
      end
      default: begin
        // padding dwords are swallowed, never forwarded
        if (cur_ff.pad_left != 4'h0) begin
          if (acc)
            nxt_cur.pad_left = cur_ff.pad_left - 4'h1;
        end else begin
          nxt_cur.state = tbcc_pkg::tbcc_st_cmd_a;
          nxt_cur.done = cur_ff.cmd_a[tbcc_pkg::A_IOC_BIT];
          if (cur_ff.cmd_a[tbcc_pkg::A_IOC_BIT])
            nxt_cur.done_sticky = 1'b1;

          // deferred command b mismatch, one pulse per buffer
          if (cur_ff.b_diff) begin
            nxt_cur.err = 1'b1;
            nxt_cur.b_diff = 1'b0;
          end

          if (cur_ff.cmd_a[tbcc_pkg::A_LAST_BIT]) begin
            nxt_cur.in_pkt = 1'b0;
            nxt_cur.have_b = 1'b0;
            nxt_cur.pkt_valid = 1'b1;
            nxt_cur.pkt_info.tag = cur_ff.cmd_b[tbcc_pkg::B_TAG_HI:tbcc_pkg::B_TAG_LO];
            // pad disable forces fcs on
            nxt_cur.pkt_info.add_fcs = !cur_ff.cmd_b[tbcc_pkg::B_NOCRC_BIT]
                                       || cur_ff.cmd_b[tbcc_pkg::B_NOPAD_BIT];
            nxt_cur.pkt_info.add_pad = !cur_ff.cmd_b[tbcc_pkg::B_NOPAD_BIT]
                                       && cur_ff.sum < tbcc_pkg::MIN_FRAME;
            nxt_cur.pkt_info.length = cur_ff.cmd_b[tbcc_pkg::LEN_HI:0];

            // error bit stays sticky until software clears it
            if (cur_ff.sum != cur_ff.cmd_b[tbcc_pkg::LEN_HI:0])
              nxt_cur.err = 1'b1;
          end
        end
      end
    endcase
    if (nxt_cur.err)
      nxt_cur.pkt_info.error = 1'b1;
    // register slave: one wait cycle, answer on the next edge
    if ((avs_read || avs_write) && !cur_ff.ack) begin
      nxt_cur.ack = 1'b1;
      nxt_cur.rdata = 32'h0;
      case (avs_address)
        tbcc_pkg::REG_STATUS: nxt_cur.rdata = {29'h0, cur_ff.in_pkt, cur_ff.pkt_info.error, cur_ff.done_sticky};
        tbcc_pkg::REG_LAST: nxt_cur.rdata = {cur_ff.pkt_info.tag, 5'h0, cur_ff.sum};
        tbcc_pkg::REG_CONTROL: nxt_cur.rdata = {31'h0, cur_ff.enable};
        default: nxt_cur.rdata = 32'h0;
      endcase
    end
    if (avs_write && cur_ff.ack) begin
      // write-one-to-clear; a same-cycle hardware set still wins
      if (avs_address == tbcc_pkg::REG_STATUS && avs_byteenable[0]) begin
        if (avs_writedata[0] && !nxt_cur.done)
          nxt_cur.done_sticky = 1'b0;
        if (avs_writedata[1] && !nxt_cur.err && !nxt_cur.pkt_valid)
          nxt_cur.pkt_info.error = 1'b0;
      end
      if (avs_address == tbcc_pkg::REG_CONTROL && avs_byteenable[0])
        nxt_cur.enable = avs_writedata[0];
    end

    // waitrequest low exactly in the answer cycle
    nxt_cur.wreq = !nxt_cur.ack;

    // stall during the end-of-buffer turn and while disabled
    nxt_cur.rdy = nxt_cur.enable &&
                  (nxt_cur.state != tbcc_pkg::tbcc_st_pad || nxt_cur.pad_left != 4'h0);
  end


  always_ff @(posedge clk) begin
    if (!resetn) begin
      cur_ff <= '0;
      cur_ff.state <= tbcc_pkg::tbcc_st_cmd_a;
      cur_ff.enable <= 1'b1;
      cur_ff.rdy <= 1'b1;
      cur_ff.wreq <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end


  assign in_ready = cur_ff.rdy;
  assign out_data = cur_ff.out_data;
  assign out_valid = cur_ff.out_valid;
  assign out_last = cur_ff.out_last;
  assign pkt_info = cur_ff.pkt_info;
  assign pkt_valid = cur_ff.pkt_valid;
  assign buffer_done_flag = cur_ff.done;
  assign transmit_error_flag = cur_ff.err;
  assign avs_readdata = cur_ff.rdata;
  assign avs_waitrequest = cur_ff.wreq;


endmodule : tbcc_checker
`default_nettype wire

// ===== tbcc_checker_test.sv
// Purpose: self-checking bench for tbcc_checker
// Assumes: flags pulse within four cycles of buffer end
// Notes: counts sampled on falling edges
`timescale 1ns/1ps
`default_nettype none
module tbcc_checker_test;
  logic clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic in_valid, in_ready, out_valid, out_last, pkt_valid, done, err, avs_waitrequest;
  logic [31:0] in_data, out_data, avs_readdata, rd, avs_writedata = 32'h0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] last_out = 32'h0;
  tbcc_pkg::tbcc_pkt_t info, got;
  int n_fail = 0, cmp_count = 0, beats = 0, lasts = 0, n_err = 0, n_done = 0;
  always #50 clk = ~clk;
  tbcc_host i_host (.clk, .in_ready, .in_data, .in_valid);
  tbcc_checker i_dut (.clk, .resetn, .in_data, .in_valid, .in_ready, .out_data, .out_valid, .out_last,
    .pkt_info(info), .pkt_valid, .buffer_done_flag(done), .transmit_error_flag(err), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest);
  always @(negedge clk) begin
    beats += int'(out_valid === 1'b1);
    lasts += int'(out_last === 1'b1);
    n_err += int'(err === 1'b1);
    n_done += int'(done === 1'b1);
    if (pkt_valid === 1'b1) got = info;
    if (out_valid === 1'b1) last_out = out_data;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic buf_end;
    repeat (4) @(negedge clk);
    @(posedge clk);
  endtask : buf_end
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, tbcc_pkg::REG_STATUS, 32'h0);
    check(rd, tbcc_pkg::REG_RESET_VAL);
    bus(1'b1, 4'hc, 32'hffffffff);
    bus(1'b0, 4'hc, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, tbcc_pkg::REG_CONTROL, 32'h0);
    @(negedge clk) check(32'(in_ready), 32'h0);
    bus(1'b1, tbcc_pkg::REG_CONTROL, 32'h1);
    i_host.send(32'h80003008, 32'h12342008);
    buf_end;
    check(last_out, 32'hd0000003);
    check(32'(got), 32'({16'h1234, 1'b0, 1'b1, 11'h008, 1'b0}));
    check({beats[7:0], lasts[7:0], n_done[7:0], n_err[7:0]}, 32'h02010100);
    bus(1'b0, tbcc_pkg::REG_LAST, 32'h0);
    check(rd, 32'h12340008);
    bus(1'b1, tbcc_pkg::REG_STATUS, 32'h1);
    i_host.send(32'h01002005, 32'h00aa3008);
    i_host.send(32'h02001003, 32'h00aa3008);
    buf_end;
    check(32'(got), 32'({16'h00aa, 1'b1, 1'b0, 11'h008, 1'b0}));
    check({beats[7:0], lasts[7:0], n_done[7:0], n_err[7:0]}, 32'h05020100);
    check(last_out, 32'hd0000002);
    i_host.send(32'h00003004, 32'h00070006);
    buf_end;
    check(32'(got.error), 32'h1);
    check({beats[7:0], lasts[7:0], n_done[7:0], n_err[7:0]}, 32'h06030101);
    bus(1'b0, tbcc_pkg::REG_STATUS, 32'h0);
    check(rd, 32'h2);
    i_host.send(32'h00002004, 32'h00080008);
    i_host.send(32'h00001004, 32'h00090008);
    buf_end;
    check({beats[7:0], lasts[7:0], n_done[7:0], n_err[7:0]}, 32'h08040102);
    bus(1'b1, tbcc_pkg::REG_STATUS, 32'h2);
    i_host.send(32'h00003040, 32'h00000040);
    buf_end;
    check(32'(got), 32'({16'h0000, 1'b1, 1'b0, 11'h040, 1'b0}));
    check({beats[7:0], lasts[7:0], n_done[7:0], n_err[7:0]}, 32'h18050102);
    finish_test;
  end
endmodule : tbcc_checker_test
`default_nettype wire

// ===== tbcc_host.sv
// Purpose: host model pushing transmit buffers
// Assumes: dword taken when valid and ready
// Notes: released data line shows the inverse
`timescale 1ns/1ps
`default_nettype none
module tbcc_host (
  input wire logic clk,
  input wire logic in_ready,
  output logic [31:0] in_data,
  output logic in_valid
);
  initial in_data = 32'h0;
  initial in_valid = 1'b0;
  task automatic send(input logic [31:0] a, input logic [31:0] b);
    int nd, blk, np;
    logic [31:0] w;
    nd = (int'(a[10:0]) + 3) / 4;
    blk = (a[25:24] == 2'h0) ? 1 : (a[25:24] == 2'h1) ? 4 : 8;
    np = (blk - nd % blk) % blk;
    @(posedge clk);
    for (int i = 0; i < nd + np + 2; i++) begin
      w = (i == 0) ? a : (i == 1) ? b : {8'hd0, 24'(i)};
      in_data <= w;
      in_valid <= 1'b1;
      do @(posedge clk); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
    in_data <= ~w;
  endtask : send
endmodule : tbcc_host
`default_nettype wire

// ===== tbcc_pkg.sv
// Purpose: constants and carriers for the transmit command checker
// Assumes: 32-bit dword stream, avalon-mm register slave
// Notes: command word field positions and register offsets
package tbcc_pkg;
  localparam int unsigned A_IOC_BIT = 31;
  localparam int unsigned A_ALIGN_HI = 25;
  localparam int unsigned A_ALIGN_LO = 24;
  localparam int unsigned A_FIRST_BIT = 13;
  localparam int unsigned A_LAST_BIT = 12;
  localparam int unsigned LEN_HI = 10;
  localparam int unsigned B_TAG_HI = 31;
  localparam int unsigned B_TAG_LO = 16;
  localparam int unsigned B_NOCRC_BIT = 13;
  localparam int unsigned B_NOPAD_BIT = 12;
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam logic [10:0] MIN_FRAME = 11'h040;
  // register offsets (byte addresses)
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_LAST = 4'h4;
  localparam logic [3:0] REG_CONTROL = 4'h8;
  localparam logic [31:0] REG_RESET_VAL = 32'h0;

  typedef enum {tbcc_st_cmd_a, tbcc_st_cmd_b, tbcc_st_data, tbcc_st_pad} tbcc_state_t;

  // per-packet transmit parameters handed to the mac side
  typedef struct packed {
    logic [15:0] tag;
    logic add_fcs;
    logic add_pad;
    logic [10:0] length;
    logic error;
  } tbcc_pkt_t;
endpackage : tbcc_pkg

// ===== tbcc_properties.sv
// Purpose: port-level checks for tbcc_checker
// Assumes: one clock, sync active-low reset
// Notes: bound to every tbcc_checker
`timescale 1ns/1ps
`default_nettype none
module tbcc_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_last,
  input wire tbcc_pkg::tbcc_pkt_t pkt_info,
  input wire logic pkt_valid,
  input wire logic buffer_done_flag,
  input wire logic transmit_error_flag,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  answer_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  fwd_data_a: assert property (out_valid |-> $past(in_valid && in_ready))
    else $error("forward without take");
  last_pkt_a: assert property (out_last |-> ##[1:8] pkt_valid)
    else $error("packet end not reported");
  no_pad_a: assert property (pkt_valid && !pkt_info.error && pkt_info.length >= tbcc_pkg::MIN_FRAME |-> !pkt_info.add_pad)
    else $error("long frame padded");
  fcs_kept_a: assert property (pkt_valid && !pkt_info.error && !pkt_info.add_pad && pkt_info.length < tbcc_pkg::MIN_FRAME |-> pkt_info.add_fcs)
    else $error("fcs dropped");
  err_at_end_a: assert property (transmit_error_flag |-> $past(!in_ready))
    else $error("error outside buffer end");
  done_at_end_a: assert property (buffer_done_flag |-> $past(!in_ready))
    else $error("done outside buffer end");
endmodule : tbcc_properties
bind tbcc_checker tbcc_properties i_props (.clk, .resetn, .in_valid, .in_ready, .out_valid, .out_last,
  .pkt_info, .pkt_valid, .buffer_done_flag, .transmit_error_flag, .avs_read, .avs_write, .avs_waitrequest);
`default_nettype wire
